// ### hdl/aise_top.v
/*
 * Added interrupt status and enable registers for an Ethernet controller,
 * behind an APB slave. Also holds the shared low status and enable bits.
 * Assumes event inputs are one-cycle pulses synchronous to pclk and the
 * process state codes come from the DMA engines on pclk.
 * Limitation: bits 14 to 0 of the added enable register are not shared here and read zero.
 * The process state codes are shown live at the read, not latched.
 */
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "aise_consts.vh"

module aise_top
(
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Process state codes
    input  wire [2:0]  tx_process_state,
    input  wire [2:0]  rx_process_state,
    // Source events, one-cycle pulses, and the PAUSE function switch level
    input  wire        tx_early_evt,
    input  wire        rx_early_evt,
    input  wire        xcvr_evt,
    input  wire        tx_deferred_evt,
    input  wire        pause_frame_evt,
    input  wire        pause_fn_on,
    input  wire [14:0] pri_low_evt,
    // Summary contributions; only the normal one shows in the primary status register, at bit 16
    output reg         pri_normal_add_q,
    output reg         pri_abnormal_add_q
);

// ----------------------------------------
// State
// ----------------------------------------
reg  [31:0] add_en_q;
reg  [14:0] pri_low_en_q;
reg  [14:0] low_status_q;
reg         tx_early_st_q;
reg         rx_early_st_q;
reg         xcvr_st_q;
reg         tx_defer_st_q;
reg         pause_st_q;
reg         ans_q;
reg         aas_q;

// Request taken while the access phase waits; a write lands at the completing edge
wire        acc   = pce & psel & penable & ~pready;
wire        done  = pce & psel & penable & pready;
wire        wr    = done & pwrite;
wire        sel_as = (paddr == `AISE_OFF_ADD_STATUS);
wire        sel_ae = (paddr == `AISE_OFF_ADD_ENABLE);
wire        sel_ps = (paddr == `AISE_OFF_PRI_STATUS);
wire        sel_pe = (paddr == `AISE_OFF_PRI_ENABLE);
wire        hit   = sel_as | sel_ae | sel_ps | sel_pe;
wire [31:0] w1c   = (wr & (sel_as | sel_ps)) ? pwdata : 32'h0000_0000;

// Set beats clear: a bit goes low only if no event arrives that cycle
function w1c_flag;
    input cur;
    input set;
    input clr;
    begin
        w1c_flag = set | (cur & ~clr);
    end
endfunction

// ----------------------------------------
// Event gating
// ----------------------------------------
wire set_te = tx_early_evt & add_en_q[`AISE_TX_EARLY_BIT];
wire set_re = rx_early_evt & add_en_q[`AISE_RX_EARLY_BIT];
wire set_x  = xcvr_evt & add_en_q[`AISE_XCVR_BIT];
wire set_td = tx_deferred_evt & add_en_q[`AISE_TX_DEFER_BIT];
wire set_pf = pause_frame_evt & pause_fn_on & add_en_q[`AISE_PAUSE_BIT];
wire any_n  = set_te | set_re;
wire any_a  = set_x | set_td | set_pf;

// ----------------------------------------
// Read mux
// ----------------------------------------
reg [31:0] rd_d;
always @*
begin
    rd_d = 32'h0000_0000;
    if (sel_as | sel_ps)
    begin
        rd_d[`AISE_TX_EARLY_BIT] = tx_early_st_q;
        rd_d[`AISE_RX_EARLY_BIT] = rx_early_st_q;
        rd_d[`AISE_XCVR_BIT]     = xcvr_st_q;
        rd_d[`AISE_TX_DEFER_BIT] = tx_defer_st_q;
        rd_d[`AISE_PAUSE_BIT]    = pause_st_q;
        rd_d[`AISE_LOW_W-1:0]    = low_status_q;
    end
    if (sel_as)
    begin
        rd_d[`AISE_TXS_HI:`AISE_TXS_LO] = tx_process_state;
        rd_d[`AISE_RXS_HI:`AISE_RXS_LO] = rx_process_state;
        rd_d[`AISE_ANS_BIT]  = ans_q;
        rd_d[`AISE_AAS_BIT]  = aas_q;
    end
    if (sel_ps)
    begin
        rd_d[`AISE_PRI_NIS_BIT] = pri_normal_add_q;
    end
    if (sel_ae)
        rd_d = add_en_q;
    if (sel_pe)
        rd_d[`AISE_LOW_W-1:0] = pri_low_en_q;
end

// ----------------------------------------
// Next values
// ----------------------------------------
// Clears only come from a completed write; an event in the same cycle wins
wire        clr_as = wr & sel_as;
// Next-state values, one per stored flag
reg  [14:0] low_d;
reg         te_d;
reg         re_d;
reg         x_d;
reg         td_d;
reg         pf_d;
reg         ans_d;
reg         aas_d;
reg         pn_d;
reg         pa_d;
integer     i;

always @*
begin
    te_d  = w1c_flag(tx_early_st_q, set_te, w1c[`AISE_TX_EARLY_BIT]);
    re_d  = w1c_flag(rx_early_st_q, set_re, w1c[`AISE_RX_EARLY_BIT]);
    x_d   = w1c_flag(xcvr_st_q, set_x, w1c[`AISE_XCVR_BIT]);
    td_d  = w1c_flag(tx_defer_st_q, set_td, w1c[`AISE_TX_DEFER_BIT]);
    pf_d  = w1c_flag(pause_st_q, set_pf, w1c[`AISE_PAUSE_BIT]);
    // Same storage via either address
    low_d = low_status_q;
    for (i = 0; i < `AISE_LOW_W; i = i + 1)
    begin
        low_d[i] = w1c_flag(low_status_q[i], pri_low_evt[i], w1c[i]);
    end
    // Summary bits clear only through the added status address
    ans_d = w1c_flag(ans_q, any_n, clr_as & pwdata[`AISE_ANS_BIT]);
    aas_d = w1c_flag(aas_q, any_a, clr_as & pwdata[`AISE_AAS_BIT]);
    // Summary enables share bits 16 and 15 of the enable register
    pn_d  = add_en_q[`AISE_ANS_BIT] & (tx_early_st_q | rx_early_st_q);
    pa_d  = add_en_q[`AISE_AAS_BIT] & (xcvr_st_q | tx_defer_st_q | pause_st_q);
end

// ----------------------------------------
// Bus response
// ----------------------------------------
// One wait state: answer in the cycle after the access phase opens
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata  <= 32'h0000_0000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end
    else if (pce)
    begin
        // Refused only outside the map; write answers carry zero data
        pready  <= acc;
        pslverr <= acc & ~hit;
        if (acc)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end
end

// ----------------------------------------
// Enable registers
// ----------------------------------------
// Reserved positions are masked on the way in, so they always read back zero
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        add_en_q     <= 32'h0000_0000;
        pri_low_en_q <= `AISE_LOW_RST;
    end
    else if (pce)
    begin
        if (wr & sel_ae)
        begin
            add_en_q <= pwdata & `AISE_EN_MASK;
        end
        if (wr & sel_pe)
        begin
            pri_low_en_q <= pwdata[`AISE_LOW_W-1:0];
        end
    end
end

// ----------------------------------------
// Event status flags
// ----------------------------------------
// A flag stays set even if its enable is dropped afterwards
// The PAUSE flag also needs the PAUSE function switched on
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tx_early_st_q <= 1'b0;
        rx_early_st_q <= 1'b0;
        xcvr_st_q     <= 1'b0;
        tx_defer_st_q <= 1'b0;
        pause_st_q    <= 1'b0;
    end
    else if (pce)
    begin
        tx_early_st_q <= te_d;
        rx_early_st_q <= re_d;
        xcvr_st_q     <= x_d;
        tx_defer_st_q <= td_d;
        pause_st_q    <= pf_d;
    end
end

// ----------------------------------------
// Shared low status
// ----------------------------------------
// Either address clears these bits, so software may use whichever it already reads
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        low_status_q <= `AISE_LOW_RST;
    end
    else if (pce)
    begin
        low_status_q <= low_d;
    end
end

// ----------------------------------------
// Summary flags
// ----------------------------------------
// Abnormal summary comes out of reset set, so software clears it once at start-up
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ans_q <= `AISE_ANS_RST;
        aas_q <= `AISE_AAS_RST;
    end
    else if (pce)
    begin
        ans_q <= ans_d;
        aas_q <= aas_d;
    end
end

// ----------------------------------------
// Primary summary contributions
// ----------------------------------------
// Registered so the outputs come from flops; this costs one cycle of lag
// A low pce freezes these too, like every other flop
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pri_normal_add_q   <= 1'b0;
        pri_abnormal_add_q <= 1'b0;
    end
    else if (pce)
    begin
        pri_normal_add_q   <= pn_d;
        pri_abnormal_add_q <= pa_d;
    end
end

endmodule

// ### hdl/aise_consts.vh
/*
 * Register offsets, field positions and reset values for the added
 * interrupt status and enable block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef AISE_CONSTS_VH
`define AISE_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AISE_OFF_PRI_STATUS   12'h028
`define AISE_OFF_ADD_STATUS   12'h080
`define AISE_OFF_ADD_ENABLE   12'h084
`define AISE_OFF_PRI_ENABLE   12'h038

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AISE_TX_EARLY_BIT     31
`define AISE_RX_EARLY_BIT     30
`define AISE_XCVR_BIT         29
`define AISE_TX_DEFER_BIT     28
`define AISE_ADD_ABN_SRC_BIT  27
`define AISE_PAUSE_BIT        26
`define AISE_TXS_HI           22
`define AISE_TXS_LO           20
`define AISE_RXS_HI           19
`define AISE_RXS_LO           17
`define AISE_ANS_BIT          16
`define AISE_AAS_BIT          15
`define AISE_LOW_W            15
`define AISE_PRI_NIS_BIT      16
`define AISE_PRI_AIS_BIT      15

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define AISE_ANS_RST          1'b0
`define AISE_AAS_RST          1'b1
`define AISE_EN_MASK          32'hf401_8000
`define AISE_LOW_RST          15'h0000

`endif

// ### dv/aise_top_props.sv
/*
 * Port-level checks for the added interrupt status and enable block.
 * Assumes it is bound to aise_top and runs on pclk.
 */
`timescale 1ns/100ps

module aise_props
(
    // Watched ports
    input wire        pclk,
    input wire        presetn,
    input wire        pce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  tx_process_state,
    input wire [2:0]  rx_process_state
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write answer always carries zero data; only read data is checked
    wire mapped = paddr == 12'h028 || paddr == 12'h038 || paddr == 12'h080 || paddr == 12'h084;
    wire rd_add = pready && !pwrite && paddr == 12'h080 && !pslverr;

    a_ready_wait: assert property (psel && penable && pce && !pready |=> pready)
        else $error("Ready missing one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready longer than one cycle");
    a_err_unmapped: assert property (pready && !mapped && !pwrite |-> pslverr && prdata == 32'h0)
        else $error("Unmapped read not refused");
    a_err_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("Mapped access refused");
    a_tx_state: assert property (rd_add |-> prdata[22:20] == $past(tx_process_state))
        else $error("Transmit state field wrong");
    a_rx_state: assert property (rd_add |-> prdata[19:17] == $past(rx_process_state))
        else $error("Receive state field wrong");
    a_en_resv: assert property (pready && !pwrite && paddr == 12'h084 |-> {prdata[27], prdata[25:17]} == 10'h0)
        else $error("Reserved enable bits not zero");
    a_st_resv: assert property (rd_add |-> {prdata[27], prdata[25:23]} == 4'h0)
        else $error("Reserved status bits not zero");

    c_rd_add: cover property (rd_add);
    c_refused: cover property (pready && pslverr);
    c_wr_pri: cover property (pready && pwrite && paddr == 12'h028);
endmodule

// ### dv/aise_top_tb.sv
/*
 * Self-checking bench for aise_top against a register model.
 * Assumes a single 250 MHz clock and event pulses driven by the bench.
 */
`timescale 1ns/100ps
`include "aise_consts.vh"

module aise_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pause_fn_on;
    logic        pri_normal_add_q, pri_abnormal_add_q;
    logic        pce;
    logic [2:0]  tx_process_state, rx_process_state;
    logic [4:0]  g;
    logic [11:0] paddr;
    logic [14:0] pri_low_evt;
    logic [31:0] pwdata, prdata, rd, en, ev, w;
    logic [31:0] seed = 32'h0000_0039;
    logic [31:0] st = 32'h0000_8000;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;

    aise_top DUT (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_process_state(tx_process_state), .rx_process_state(rx_process_state), .tx_early_evt(tx_early_evt),
        .rx_early_evt(rx_early_evt), .xcvr_evt(xcvr_evt), .tx_deferred_evt(tx_deferred_evt),
        .pause_frame_evt(pause_frame_evt), .pause_fn_on(pause_fn_on), .pri_low_evt(pri_low_evt),
        .pri_normal_add_q(pri_normal_add_q), .pri_abnormal_add_q(pri_abnormal_add_q));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Master holds the request until it samples pready; no cycle count assumed
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tx_process_state, rx_process_state} = '0;
        {tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pause_fn_on, pri_low_evt} = '0;
        pce = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h084, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h084, 32'hffff_ffff);
        apb(1'b0, 12'h084, 32'h0);
        chk(rd, 32'hf401_8000);
        apb(1'b1, 12'h100, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1);
        for (int k = 0; k < 60; k++)
        begin
            en = rnd() & `AISE_EN_MASK;
            apb(1'b1, 12'h084, en);
            ev = rnd();
            {tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pause_fn_on} <= ev[5:0];
            pri_low_evt <= ev[20:6];
            tx_process_state <= ev[23:21];
            rx_process_state <= ev[26:24];
            g = {ev[5:2], ev[1] & ev[0]} & {en[31:28], en[26]};
            @(posedge pclk);
            {tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pri_low_evt} <= '0;
            st = st | {g[4:1], 1'b0, g[0], 9'h0, |g[4:3], |g[2:0], ev[20:6]};
            @(posedge pclk);
            apb(1'b0, 12'h080, 32'h0);
            chk(rd, st | {9'h0, tx_process_state, rx_process_state, 17'h0});
            chk({31'h0, pri_normal_add_q}, {31'h0, en[16] & (st[31] | st[30])});
            chk({31'h0, pri_abnormal_add_q}, {31'h0, en[15] & (st[29] | st[28] | st[26])});
            apb(1'b0, 12'h028, 32'h0);
            chk(rd, (st & 32'hf400_7fff) | {15'h0, en[16] & (st[31] | st[30]), 16'h0});
            w = rnd();
            apb(1'b1, k[0] ? 12'h028 : 12'h080, w);
            st = st & ~(w & (k[0] ? 32'hf400_7fff : 32'hf401_ffff));
        end
        // Primary enable low bits read back what was written
        apb(1'b1, 12'h038, w);
        apb(1'b0, 12'h038, 32'h0);
        chk(rd, w & 32'h0000_7fff);
        // Clock enable low: events with every enable set must leave all flags alone
        apb(1'b1, 12'h084, `AISE_EN_MASK);
        pce <= 1'b0;
        {tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pause_fn_on} <= 6'h3f;
        pri_low_evt <= 15'h7fff;
        @(posedge pclk);
        {tx_early_evt, rx_early_evt, xcvr_evt, tx_deferred_evt, pause_frame_evt, pri_low_evt} <= '0;
        pce <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h080, 32'h0);
        chk(rd, st | {9'h0, tx_process_state, rx_process_state, 17'h0});
        // Reset in mid-run restores the documented defaults
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h080, 32'h0);
        chk(rd, {9'h0, tx_process_state, rx_process_state, 17'h0} | 32'h0000_8000);
        apb(1'b0, 12'h084, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule

bind aise_top aise_props u_props (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_process_state(tx_process_state), .rx_process_state(rx_process_state));
